// *** shared/cpt_regs.svh ***
// Purpose: Register indices, field positions, reset values and taps of the pulse train timer
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef CPT_REGS_SVH
`define CPT_REGS_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define CPT_IDX_CH0_CTL   24'hff_ffb0
`define CPT_IDX_CH1_CTL   24'hff_ffb1
`define CPT_IDX_CH0_FLG   24'hff_ffb2
`define CPT_IDX_CH1_FLG   24'hff_ffb3
`define CPT_IDX_CH0_CMPA  24'hff_ffb4
`define CPT_IDX_CH1_CMPA  24'hff_ffb5
`define CPT_IDX_CH0_CMPB  24'hff_ffb6
`define CPT_IDX_CH0_CNT   24'hff_ffb8
`define CPT_IDX_CH1_CNT   24'hff_ffb9
`define CPT_IDX_CH0_PSC   24'hff_ffba
`define CPT_IDX_CH1_PSC   24'hff_ffbb
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPT_CTL_IRQ_EN    6
`define CPT_FLG_MATCH_B   7
`define CPT_FLG_MATCH_A   6
// ----------------------------------------
// Reset values and divider taps
// ----------------------------------------
`define CPT_RST_BYTE      8'h00
`define CPT_TAP_DIV2      0
`define CPT_TAP_DIV8      2
`define CPT_TAP_DIV32     4
`define CPT_TAP_DIV64     5
`define CPT_TAP_DIV1024   9
`define CPT_TAP_DIV8192   12
`endif

// *** shared/cpt_pkg.sv ***
// Purpose: Types of the pulse train timer
// Assumes: Two channels
// Notes:   Constants live in cpt_regs.svh
package cpt_pkg;
	// ----------------------------------------
	// Field encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		CPT_SRC_OFF    = 3'b000,
		CPT_SRC_FAST   = 3'b001,
		CPT_SRC_MID    = 3'b010,
		CPT_SRC_SLOW   = 3'b011,
		CPT_SRC_CASC   = 3'b100
	} cpt_src_t;
	typedef enum logic [1:0] {
		CPT_OUT_KEEP   = 2'b00,
		CPT_OUT_LOW    = 2'b01,
		CPT_OUT_HIGH   = 2'b10,
		CPT_OUT_TOGGLE = 2'b11
	} cpt_out_t;
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] flg;
		logic [1:0] psc;
		logic [7:0] cmp_a;
		logic [7:0] cnt;
		logic       eq_a;
	} cpt_chan_t;
	typedef struct packed {
		cpt_chan_t [1:0] ch;
		logic [7:0]      cmp_b;
		logic            eq_b;
		logic            pin;
		logic [12:0]     div;
		logic            ovf1;
		logic            hit_a0;
		logic            ack;
		logic [7:0]      rdat;
	} cpt_state_t;
endpackage

// *** hw/cpt_timer.sv ***
// Purpose: Two cascaded 8-bit timer channels driving a counted pulse train
// Assumes: Peripheral clock is clk_i; classic Wishbone slave, 32-bit data
// Notes:   Registers sit in the low byte of each word
//
// Overview of operation
// [RULE1] Source 001 counts clock/8 or /2; choice bit 1 picks falling edge.
// [RULE2] Source 010 counts clock/64 or /32; choice bit 1 picks falling edge.
// [RULE3] Source 011 counts clock/8192 or /1024; choice bit 1 picks falling edge.
// [RULE4] Source 000 stops the counter; it holds its value.
// [RULE5] Channel 0 source 100 counts channel 1 overflows.
// [RULE6] Channel 1 source 100 counts channel 0 match A events.
// [RULE7] Clear field 01 zeroes the counter on match with compare A.
// [RULE8] Counter always compared with compare A; equality sets match A flag.
// [RULE9] Channel 0 counter compared with compare B; equality sets match B flag.
// [RULE10] Match A flag sits at bit 6 of the flag register.
// [RULE11] Channel 1 control bit 6 gates the match A interrupt request.
// [RULE12] Match B drives pin per select bits 3:2: 00 keep, 01 low.
// [RULE13] Match A drives pin per select bits 1:0: 00 keep, 10 high.
// [RULE14] Both counters are software readable and writable bytes.
// [RULE15] Software stops the train by clearing selects and interrupt enable.
// [RULE16] Software loads period, half period, configures, clears, then enables.
// [RULE17] Channel 0 clear on compare A sets the pulse period.
// [RULE18] Match flags stay set until software writes zero to them.
`timescale 1ns/1ns
`default_nettype none
`include "cpt_regs.svh"
module cpt_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             pulse_out_o,
	output logic      [1:0]  irq_o
);
	cpt_pkg::cpt_state_t s_q;
	cpt_pkg::cpt_state_t s_d;

	// ----------------------------------------
	// Divider and tick selection
	// ----------------------------------------

	// Next divider value, used to spot tap edges
	logic [12:0] div_nx;
	assign div_nx = s_q.div + 13'h0001;

	logic [1:0] tick;
	logic [1:0] eq_a;
	logic       eq_b;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			logic [2:0] src;
			logic [1:0] ics;
			int         tap;
			logic       now;
			logic       nxt;
			logic       edge_hit;
			logic       casc;
			assign src = s_q.ch[gi].ctl[2:0];
			assign ics = s_q.ch[gi].psc;
			// Tap bit of the free divider for this source
			always_comb begin
				tap = `CPT_TAP_DIV8;
				unique case (src)
					cpt_pkg::CPT_SRC_FAST: tap = ics[0] ? `CPT_TAP_DIV2 : `CPT_TAP_DIV8;      // [RULE1]
					cpt_pkg::CPT_SRC_MID:  tap = ics[0] ? `CPT_TAP_DIV32 : `CPT_TAP_DIV64;    // [RULE2]
					cpt_pkg::CPT_SRC_SLOW: tap = ics[0] ? `CPT_TAP_DIV1024 : `CPT_TAP_DIV8192; // [RULE3]
					default:               tap = `CPT_TAP_DIV8;
				endcase
			end
			assign now = s_q.div[tap];
			assign nxt = div_nx[tap];
			// Upper choice bit selects the falling edge of the divided clock
			assign edge_hit = ics[1] ? (now & ~nxt) : (~now & nxt); // [RULE1] [RULE2] [RULE3]
			// Cascade input: ch0 takes ch1 overflow, ch1 takes ch0 match A
			assign casc = (gi == 0) ? s_q.ovf1 : s_q.hit_a0; // [RULE5] [RULE6]
			always_comb begin
				unique case (src)
					cpt_pkg::CPT_SRC_FAST,
					cpt_pkg::CPT_SRC_MID,
					cpt_pkg::CPT_SRC_SLOW: tick[gi] = edge_hit;
					cpt_pkg::CPT_SRC_CASC: tick[gi] = casc;
					default:               tick[gi] = 1'b0; // [RULE4]
				endcase
			end
			// Continuous comparison with compare A
			assign eq_a[gi] = (s_q.ch[gi].cnt == s_q.ch[gi].cmp_a); // [RULE8]
		end
	endgenerate

	assign eq_b = (s_q.ch[0].cnt == s_q.cmp_b); // [RULE9]

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	logic        req;
	logic        wr;
	logic [23:0] idx;
	logic [7:0]  wb;
	// A request is a cycle with both cyc and stb high
	assign req = cyc_i & stb_i;
	// Word index; the two low address bits are ignored
	assign idx = adr_i[25:2];
	// Only byte lane 0 carries register data; a write with
	// sel_i[0] low is still answered but changes nothing
	// Write lands at the edge the master sees ack
	assign wr  = req & we_i & s_q.ack & sel_i[0];
	assign wb  = dat_i[7:0];

	// Read multiplexer; unmapped indices read zero
	logic [7:0] rd;
	always_comb begin
		rd = 8'h00;
		if (adr_i[31:26] == 6'h00) begin
			unique case (idx)
				`CPT_IDX_CH0_CTL:  rd = s_q.ch[0].ctl;
				`CPT_IDX_CH1_CTL:  rd = s_q.ch[1].ctl;
				`CPT_IDX_CH0_FLG:  rd = s_q.ch[0].flg; // [RULE10]
				`CPT_IDX_CH1_FLG:  rd = s_q.ch[1].flg; // [RULE10]
				`CPT_IDX_CH0_CMPA: rd = s_q.ch[0].cmp_a;
				`CPT_IDX_CH1_CMPA: rd = s_q.ch[1].cmp_a;
				`CPT_IDX_CH0_CMPB: rd = s_q.cmp_b;
				`CPT_IDX_CH0_CNT:  rd = s_q.ch[0].cnt; // [RULE14]
				`CPT_IDX_CH1_CNT:  rd = s_q.ch[1].cnt; // [RULE14]
				`CPT_IDX_CH0_PSC:  rd = {6'h00, s_q.ch[0].psc};
				`CPT_IDX_CH1_PSC:  rd = {6'h00, s_q.ch[1].psc};
				default:           rd = 8'h00;
			endcase
		end
	end

	// Per-register write strobes
	logic hi_ok;
	assign hi_ok = (adr_i[31:26] == 6'h00);
	logic [1:0] w_ctl;
	logic [1:0] w_flg;
	logic [1:0] w_cmpa;
	logic [1:0] w_cnt;
	logic [1:0] w_psc;
	logic       w_cmpb;
	assign w_ctl[0]  = wr & hi_ok & (idx == `CPT_IDX_CH0_CTL);
	assign w_ctl[1]  = wr & hi_ok & (idx == `CPT_IDX_CH1_CTL);
	assign w_flg[0]  = wr & hi_ok & (idx == `CPT_IDX_CH0_FLG);
	assign w_flg[1]  = wr & hi_ok & (idx == `CPT_IDX_CH1_FLG);
	assign w_cmpa[0] = wr & hi_ok & (idx == `CPT_IDX_CH0_CMPA);
	assign w_cmpa[1] = wr & hi_ok & (idx == `CPT_IDX_CH1_CMPA);
	assign w_cnt[0]  = wr & hi_ok & (idx == `CPT_IDX_CH0_CNT);
	assign w_cnt[1]  = wr & hi_ok & (idx == `CPT_IDX_CH1_CNT);
	assign w_psc[0]  = wr & hi_ok & (idx == `CPT_IDX_CH0_PSC);
	assign w_psc[1]  = wr & hi_ok & (idx == `CPT_IDX_CH1_PSC);
	assign w_cmpb    = wr & hi_ok & (idx == `CPT_IDX_CH0_CMPB);

	// ----------------------------------------
	// Match events
	// ----------------------------------------

	// A match event is the first cycle of equality
	logic [1:0] hit_a;
	logic       hit_b;
	assign hit_a = eq_a & ~{s_q.ch[1].eq_a, s_q.ch[0].eq_a}; // [RULE8]
	assign hit_b = eq_b & ~s_q.eq_b;                          // [RULE9]

	// Pin level after match actions; match A applied last
	logic     pin_b;
	logic     pin_n;
	cpt_pkg::cpt_out_t os_b;
	cpt_pkg::cpt_out_t os_a;
	assign os_b = cpt_pkg::cpt_out_t'(s_q.ch[0].flg[3:2]);
	assign os_a = cpt_pkg::cpt_out_t'(s_q.ch[0].flg[1:0]);
	always_comb begin
		pin_b = s_q.pin;
		if (hit_b) begin
			unique case (os_b) // [RULE12]
				cpt_pkg::CPT_OUT_KEEP:   pin_b = s_q.pin;
				cpt_pkg::CPT_OUT_LOW:    pin_b = 1'b0;
				cpt_pkg::CPT_OUT_HIGH:   pin_b = 1'b1;
				cpt_pkg::CPT_OUT_TOGGLE: pin_b = ~s_q.pin;
			endcase
		end
		pin_n = pin_b;
		if (hit_a[0]) begin
			unique case (os_a) // [RULE13]
				cpt_pkg::CPT_OUT_KEEP:   pin_n = pin_b;
				cpt_pkg::CPT_OUT_LOW:    pin_n = 1'b0;
				cpt_pkg::CPT_OUT_HIGH:   pin_n = 1'b1;
				cpt_pkg::CPT_OUT_TOGGLE: pin_n = ~pin_b;
			endcase
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	logic [7:0] fset;
	logic [7:0] fnew;
	always_comb begin
		s_d  = s_q;
		fset = 8'h00;
		fnew = 8'h00;
		s_d.div    = div_nx;
		s_d.eq_b   = eq_b;
		s_d.pin    = pin_n;
		s_d.hit_a0 = hit_a[0];
		s_d.ovf1   = 1'b0;
		// Bus answer: one ack per request, data captured with it
		s_d.ack  = req & ~s_q.ack;
		// Read data taken once per request and held until the next one,
		// so a slow master still sees the byte it asked for
		if (req & ~s_q.ack) begin
			s_d.rdat = rd;
		end
		if (w_cmpb) begin
			s_d.cmp_b = wb;
		end
		for (int i = 0; i < 2; i++) begin
			s_d.ch[i].eq_a = eq_a[i];
			// Counter: clear on compare A, else count on tick
			if (tick[i]) begin
				if (s_q.ch[i].ctl[4:3] == 2'b01 && eq_a[i]) begin
					s_d.ch[i].cnt = 8'h00; // [RULE7] [RULE17]
				end else begin
					s_d.ch[i].cnt = s_q.ch[i].cnt + 8'h01;
				end
			end
			// Software write to the counter wins over counting
			if (w_cnt[i]) begin
				s_d.ch[i].cnt = wb; // [RULE14]
			end
			if (w_ctl[i]) begin
				s_d.ch[i].ctl = wb;
			end
			if (w_cmpa[i]) begin
				s_d.ch[i].cmp_a = wb;
			end
			if (w_psc[i]) begin
				s_d.ch[i].psc = wb[1:0];
			end
			// Flags: zero written clears, hardware set wins
			fset = 8'h00;
			fset[`CPT_FLG_MATCH_A] = hit_a[i];       // [RULE8] [RULE10]
			if (i == 0) begin
				fset[`CPT_FLG_MATCH_B] = hit_b;      // [RULE9]
			end
			fnew = s_q.ch[i].flg;
			if (w_flg[i]) begin
				fnew[`CPT_FLG_MATCH_A] = s_q.ch[i].flg[`CPT_FLG_MATCH_A] & wb[`CPT_FLG_MATCH_A]; // [RULE18]
				fnew[`CPT_FLG_MATCH_B] = s_q.ch[i].flg[`CPT_FLG_MATCH_B] & wb[`CPT_FLG_MATCH_B]; // [RULE18]
				fnew[5:0] = (i == 0) ? {2'b00, wb[3:0]} : 6'h00;
			end
			fnew[`CPT_FLG_MATCH_A] = fnew[`CPT_FLG_MATCH_A] | fset[`CPT_FLG_MATCH_A];
			fnew[`CPT_FLG_MATCH_B] = (i == 0) & (fnew[`CPT_FLG_MATCH_B] | fset[`CPT_FLG_MATCH_B]);
			s_d.ch[i].flg = fnew;
		end
		// Channel 1 wraps from ff to 00 on a counting tick
		s_d.ovf1 = tick[1] & ~w_cnt[1] & (s_d.ch[1].cnt == 8'h00) & (s_q.ch[1].cnt == 8'hff); // [RULE5]
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------

	// Single register for all state; reset clears every field,
	// which leaves the pin low and both interrupts quiet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Upper read bits are always zero; only the low lane is used
	assign dat_o       = {24'h00_0000, s_q.rdat};
	assign ack_o       = s_q.ack;
	assign pulse_out_o = s_q.pin;
	// Interrupt requests gated by each control's enable bit;
	// they are levels that stay up until the flag is written 0
	// or the enable is cleared by software
	assign irq_o[0] = s_q.ch[0].flg[`CPT_FLG_MATCH_A] & s_q.ch[0].ctl[`CPT_CTL_IRQ_EN];
	assign irq_o[1] = s_q.ch[1].flg[`CPT_FLG_MATCH_A] & s_q.ch[1].ctl[`CPT_CTL_IRQ_EN]; // [RULE11]
endmodule
`default_nettype wire

// *** sim/cpt_timer_props.sv ***
// Purpose: Bus and pin properties of the pulse train timer
// Assumes: Sees only the top module ports
// Notes:   Bound to every timer instance
`timescale 1ns/1ns
`default_nettype none
`include "cpt_regs.svh"
module cpt_timer_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        pulse_out_o,
	input wire logic [1:0]  irq_o
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// New request, read answer, and map hit
	wire req = cyc_i && stb_i && !ack_o;
	wire rd = ack_o && !we_i;
	wire hit = adr_i[31:6] == 26'h0f_fffb && adr_i[5:2] != 4'h7 && adr_i[5:2] <= 4'hb;
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
	ack_answer_a: assert property (req |=> ack_o) else $error("no ack");
	read_upper_a: assert property (rd |-> dat_o[31:8] == 24'h00_0000) else $error("upper bits");
	read_hold_a: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
	unmapped_zero_a: assert property (rd && !hit |-> dat_o == 32'h0000_0000) else $error("unmapped read");
	flag_bits_a: assert property (rd && hit && adr_i[5:2] == 4'h3 |-> dat_o[7:0] == 8'h00 || dat_o[7:0] == 8'h40)
		else $error("flag bits");
	reset_quiet_a: assert property ($fell(rst_i) |-> !pulse_out_o && irq_o == 2'h0) else $error("reset state");
	irq_drop_a: assert property ($fell(irq_o[1]) |-> $past(ack_o && we_i)) else $error("irq fell");
	irq_seen_c: cover property ($rose(irq_o[1]));
	pin_rise_c: cover property ($rose(pulse_out_o));
	unmapped_c: cover property (rd && !hit);
endmodule
bind cpt_timer cpt_timer_props props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pulse_out_o(pulse_out_o), .irq_o(irq_o));
`default_nettype wire

// *** sim/cpt_cpu_model.sv ***
// Purpose: Software side of the timer
// Assumes: Classic Wishbone master, one request at a time
// Notes:   stuck_o rises when a request gets no ack
`timescale 1ns/1ns
`default_nettype none
`include "cpt_regs.svh"
module cpt_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output var logic         cyc_o,
	output var logic         stb_o,
	output var logic         we_o,
	output var logic  [31:0] adr_o,
	output var logic  [3:0]  sel_o,
	output var logic  [31:0] dat_o,
	output var logic         stuck_o
);
	// ----
	// Bus cycle
	// ----
	initial begin
		{cyc_o, stb_o, we_o, adr_o, dat_o, stuck_o} = '0;
		sel_o = 4'h1;
	end
	// Hold the request until ack is sampled high
	task automatic bus(input logic w, input logic [23:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o} <= {2'h3, w};
		adr_o <= {6'h00, idx, 2'h0};
		dat_o <= {24'h00_0000, wd};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 16);
		stuck_o <= ack_i !== 1'b1;
		rd = dat_i[7:0];
		{cyc_o, stb_o} <= 2'h0;
	endtask
	task automatic wr(input logic [23:0] idx, input logic [7:0] wd);
		logic [7:0] nc;
		bus(1'b1, idx, wd, nc);
	endtask
	// ----
	// Train start and stop
	// ----
	task automatic start_train(input logic [7:0] period, input logic [7:0] count);
		wr(`CPT_IDX_CH0_CMPA, period);
		wr(`CPT_IDX_CH0_CMPB, period >> 1);
		wr(`CPT_IDX_CH0_PSC, 8'h01); // Divide by 2
		wr(`CPT_IDX_CH0_CTL, 8'h09); // Clear on A, prescaled clock
		wr(`CPT_IDX_CH0_FLG, 8'h06); // B drives low, A drives high
		wr(`CPT_IDX_CH1_CMPA, count);
		wr(`CPT_IDX_CH1_CTL, 8'h0c); // Clear on A, cascade
		wr(`CPT_IDX_CH0_CNT, 8'h00);
		wr(`CPT_IDX_CH1_CNT, 8'h00);
		wr(`CPT_IDX_CH1_FLG, 8'h00); // Stale match from reset
		wr(`CPT_IDX_CH1_CTL, 8'h4c);
	endtask
	task automatic stop_train();
		wr(`CPT_IDX_CH0_FLG, 8'h00);
		wr(`CPT_IDX_CH1_CTL, 8'h0c);
	endtask
endmodule
`default_nettype wire

// *** sim/cpt_timer_bench.sv ***
// Purpose: Self-checking bench of the pulse train timer
// Assumes: cpt_cpu_model issues every bus cycle
// Notes:   Divider counts allow one tick of phase slack
`timescale 1ns/1ns
`default_nettype none
`include "cpt_regs.svh"
module cpt_timer_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, ack, pin, pin_q, stuck;
	logic [31:0] adr, wdat, rdat;
	logic [3:0]  sel;
	logic [1:0]  irq;
	logic [7:0]  v, p;
	int          bad_count = 0;
	int          tests_run = 0;
	int          n, last, per;
	logic [2:0]  src_tab [7] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
	logic [1:0]  psc_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2};
	int          div_tab [7] = '{8, 2, 8, 64, 32, 1024, 8192};
	// ----
	// Clock, instances and checks
	// ----
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) pin_q <= pin;
	cpt_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pulse_out_o(pin), .irq_o(irq));
	cpt_cpu_model cpu_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat), .stuck_o(stuck));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got, input logic tol);
		tests_run++;
		if (got !== exp && !(tol && (got === exp + 8'h01 || got === exp - 8'h01))) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// An unanswered request ends the run
	always @(posedge clk_i) begin
		if (stuck === 1'b1) begin
			bad_count++;
			final_report();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		cpu_u.bus(1'b0, `CPT_IDX_CH0_CNT, 8'h00, v);
		chk("count0 reset", 8'h00, v, 1'b0);
		cpu_u.wr(`CPT_IDX_CH0_CNT, 8'h5a);
		cpu_u.bus(1'b0, `CPT_IDX_CH0_CNT, 8'h00, v);
		chk("count0 readback", 8'h5a, v, 1'b0);
		cpu_u.bus(1'b0, 24'hff_ffb7, 8'h00, v);
		chk("unmapped read", 8'h00, v, 1'b0);
		$display("test registers done");
		// Four ticks of each source, window trimmed by the bus cycles
		for (int i = 0; i < 7; i++) begin
			cpu_u.wr(`CPT_IDX_CH0_PSC, {6'h00, psc_tab[i]});
			cpu_u.wr(`CPT_IDX_CH0_CNT, 8'h00);
			cpu_u.wr(`CPT_IDX_CH0_CTL, {5'h00, src_tab[i]});
			repeat (div_tab[i] * 4 - 3) @(posedge clk_i);
			cpu_u.wr(`CPT_IDX_CH0_CTL, 8'h00);
			cpu_u.bus(1'b0, `CPT_IDX_CH0_CNT, 8'h00, v);
			chk("divided count", 8'h04, v, 1'b1);
		end
		cpu_u.wr(`CPT_IDX_CH0_CNT, 8'h07);
		repeat (40) @(posedge clk_i);
		cpu_u.bus(1'b0, `CPT_IDX_CH0_CNT, 8'h00, v);
		chk("count0 stopped", 8'h07, v, 1'b0);
		$display("test clock sources done");
		cpu_u.start_train(8'h09, 8'h03);
		n = 0;
		last = 0;
		per = 0;
		for (int k = 0; k < 400 && irq[1] !== 1'b1; k++) begin
			@(posedge clk_i);
			if (pin === 1'b1 && pin_q === 1'b0) begin
				n++;
				per = k - last;
				last = k;
			end
		end
		if (irq[1] !== 1'b1) begin
			bad_count++;
			final_report();
		end
		chk("pulses", 8'h03, n[7:0], 1'b0);
		chk("period", 8'h14, per[7:0], 1'b0);
		cpu_u.bus(1'b0, `CPT_IDX_CH0_FLG, 8'h00, v);
		chk("flags0", 8'hc6, v, 1'b0);
		cpu_u.stop_train();
		cpu_u.bus(1'b0, `CPT_IDX_CH1_FLG, 8'h00, v);
		chk("flags1 kept", 8'h40, v, 1'b0);
		chk("irq masked", 8'h00, {6'h00, irq}, 1'b0);
		cpu_u.wr(`CPT_IDX_CH1_FLG, 8'h00);
		cpu_u.bus(1'b0, `CPT_IDX_CH1_FLG, 8'h00, v);
		chk("flags1 cleared", 8'h00, v, 1'b0);
		p = {7'h00, pin};
		repeat (100) @(posedge clk_i);
		chk("pin held", p, {7'h00, pin}, 1'b0);
		$display("test pulse train done");
		final_report();
	end
endmodule
`default_nettype wire
